// ---- hw/isvm_consts.svh ----
// constants for the interrupt source vector map: offsets, vectors, field positions
`ifndef ISVM_CONSTS_SVH
`define ISVM_CONSTS_SVH
// register byte offsets on the bus
`define ISVM_OFF_TBASE    12'h000
`define ISVM_OFF_FLAGS    12'h004
`define ISVM_OFF_MATCHEN  12'h008
`define ISVM_OFF_SRCSEL   12'h00c
`define ISVM_OFF_MADDR0   12'h010
`define ISVM_OFF_SPECIAL  12'h020
`define ISVM_OFF_LASTNUM  12'h024
`define ISVM_OFF_LASTADDR 12'h028
`define ISVM_SRC_PAGE     4'h1
// fixed vector region and entries
`define ISVM_FIX_LO       20'hfffdc
`define ISVM_FIX_HI       20'hfffff
`define ISVM_VEC_UND      20'hfffdc
`define ISVM_VEC_OVF      20'hfffe0
`define ISVM_VEC_BRK      20'hfffe4
`define ISVM_VEC_BRK_TOP  20'hfffe7
`define ISVM_VEC_MATCH    20'hfffe8
`define ISVM_VEC_SHARED   20'hffff0
`define ISVM_VEC_NMI      20'hffff8
`define ISVM_BRK_RELOC    8'hff
// relocatable table
`define ISVM_TABLE_BYTES  12'h100
`define ISVM_ENTRY_BYTES  3'h4
`define ISVM_SW_USTACK_LO 6'h20
`define ISVM_IPL_SPECIAL  3'h7
`define ISVM_PRIO_OFF     3'h0
// fields of a per-source control word
`define ISVM_SRC_REQ_BIT  3
// numbers whose vector carries ack/no_acknowledge_event or start/stop in two-wire mode
`define ISVM_TWO_WIRE_SET 64'h000f_f800_001f_84c0
// reset values
`define ISVM_RST_TBASE    20'h00000
`define ISVM_RST_FLAGS    6'h00
`endif

// ---- hw/isvm_pkg.sv ----
// types shared by the interrupt source vector map
package isvm_pkg;
    // instruction that raises a software interrupt
    typedef enum logic [1:0] {OP_UNDEF, OP_OVF_TRAP, OP_BREAK, OP_SWINT} isvm_op_t;
    // source class of an accepted entry
    typedef enum logic [2:0] {SRC_UNDEF, SRC_OVF, SRC_BREAK, SRC_SWINT, SRC_NMI,
                              SRC_SHARED, SRC_MATCH, SRC_PERIPH} isvm_src_t;
    typedef enum {ST_IDLE, ST_PROBE, ST_ALIGN, ST_FETCH, ST_DONE} isvm_state_t;
    // processor flag word as held here
    typedef struct packed {
        logic [2:0] processor_priority_level;
        logic       u;
        logic       o;
        logic       i;
    } isvm_flags_t;
    typedef struct packed {
        logic       valid;
        isvm_op_t   op;
        logic [5:0] num;
    } isvm_instr_t;
    typedef struct packed {
        logic        valid;
        isvm_src_t   src;
        logic [5:0]  num;
        logic [19:0] addr;
        isvm_flags_t saved;
    } isvm_entry_t;
endpackage : isvm_pkg

// ---- hw/isvm_top.sv ----
// interrupt source classification, vector fetch and flag handling with apb registers
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "isvm_consts.svh"

// Operation
// [RULE1] each vector entry is four bytes; entry branches to the address fetched
// [RULE2] fixed region spans FFFDCh..FFFFFh, independent of the table base
// [RULE3] undefined-opcode at FFFDCh, overflow at FFFE0h, breakpoint at FFFE4h
// [RULE4] timeout, oscillator and low-supply share FFFF0h; sticky flags identify source
// [RULE5] byte FFFE7h equal to FFh sends breakpoint through relocatable entry 0
// [RULE6] relocatable table is 256 bytes from the table base
// [RULE7] odd table base costs one extra cycle per entry sequence
// [RULE8] software number n vector lies at base plus four times n
// [RULE9] software-interrupt instruction takes numbers 0 to 63 via the table
// [RULE10] numbers 2-31 and 41-51 share entries with peripheral sources
// [RULE11] numbers 0-31 save the stack-select flag, clear it, restore on return
// [RULE12] numbers 32-63 leave the stack-select flag unchanged
// [RULE13] undefined-opcode instruction always traps
// [RULE14] overflow-trap instruction traps only when overflow flag is 1
// [RULE15] breakpoint instruction always traps
// [RULE16] instruction interrupts ignore global enable and priority levels
// [RULE17] non-maskable request on falling edge of its pin
// [RULE18] address match fires before executing an enabled match address
// [RULE19] peripheral requests are maskable and latched when raised
// [RULE20] entry 0 and numbers 32-40 are never blocked by global enable
// [RULE21] numbers 6-9 pick between two sources by select bits
// [RULE22] two-wire mode routes ack/no_acknowledge_event and start/stop events to those vectors
// [RULE23] maskable accept needs enable, request flag and level above current
// [RULE24] priority 000b disables, 001b-111b are levels 1-7
// [RULE25] entry bytes read low address first, little-endian
module isvm_top
    import isvm_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // cpu sequencer side
    input  wire isvm_instr_t instrReq,
    input  wire logic        execStrobe,
    input  wire logic [19:0] execAddr,
    input  wire logic        retStrobe,
    input  wire isvm_flags_t retFlags,
    output logic             seqBusy,
    output isvm_entry_t      entry,
    output isvm_flags_t      flags,
    // vector byte fetch
    output logic             vfReq,
    output logic      [19:0] vfAddr,
    input  wire logic [7:0]  vfData,
    input  wire logic        vfAck,
    // request sources
    input  wire logic        nmiPin_n,
    input  wire logic        timeoutReq,
    input  wire logic        oscReq,
    input  wire logic        lowSupplyReq,
    input  wire logic [63:0] periphReq,
    input  wire logic [3:0]  altReq,
    input  wire logic [63:0] twoWireReq
);

    // relocatable entry address: base plus four times the number
    function automatic logic [19:0] relAddr(input logic [19:0] base, input logic [5:0] n);
        relAddr = base + {12'h000, n, 2'b00};                              // [RULE6]
    endfunction

    // register state
    logic [19:0] vector_table_base;
    logic [3:0]  matchEn;          // [1:0] match_enable_low, [3:2] match_enable_high
    logic [4:0]  srcSel;           // select bits for 8,9,6,7 and two-wire mode
    logic [19:0] matchAddr [4];
    logic [2:0]  srcPrio [64];
    logic [63:0] request_pending_flag;
    logic [2:0]  specialFlags;     // timeout, oscillator, low supply
    logic        specialPend;
    logic [5:0]  lastNum;
    logic [19:0] lastAddr;

    // sequencer state
    isvm_state_t state;
    logic [1:0]  byteCnt;
    logic [19:0] fetchBase;
    logic [23:0] shiftIn;
    logic        nmiS1;
    logic        nmiS2;
    logic        nmiPrev;
    logic        nmiPend;

    // apb decode
    wire        apbAcc   = psel & penable & ~pready;
    wire        apbWr    = apbAcc & pwrite;
    wire        srcHit   = (paddr[11:8] == `ISVM_SRC_PAGE);
    wire [5:0]  srcIdx   = paddr[7:2];
    wire [11:0] mAddrLo  = `ISVM_OFF_MADDR0;
    wire        mAddrHit = (paddr[11:4] == mAddrLo[11:4]);
    wire [1:0]  mIdx     = paddr[3:2];
    wire        regHit   = (paddr == `ISVM_OFF_TBASE) | (paddr == `ISVM_OFF_FLAGS)
                         | (paddr == `ISVM_OFF_MATCHEN) | (paddr == `ISVM_OFF_SRCSEL)
                         | (paddr == `ISVM_OFF_SPECIAL) | (paddr == `ISVM_OFF_LASTNUM)
                         | (paddr == `ISVM_OFF_LASTADDR);
    wire        mapped   = (paddr[1:0] == 2'b00) & (regHit | mAddrHit | srcHit);

    // read data selection
    logic [31:0] rdSel;
    always_comb begin
        rdSel = 32'h0000_0000;
        if (srcHit) begin
            rdSel = {28'h0, request_pending_flag[srcIdx], srcPrio[srcIdx]};
        end else if (mAddrHit) begin
            rdSel = {12'h000, matchAddr[mIdx]};
        end else begin
            case (paddr)
                `ISVM_OFF_TBASE:    rdSel = {12'h000, vector_table_base};
                `ISVM_OFF_FLAGS:    rdSel = {26'h0, flags};
                `ISVM_OFF_MATCHEN:  rdSel = {28'h0, matchEn};
                `ISVM_OFF_SRCSEL:   rdSel = {27'h0, srcSel};
                `ISVM_OFF_SPECIAL:  rdSel = {29'h0, specialFlags};
                `ISVM_OFF_LASTNUM:  rdSel = {26'h0, lastNum};
                `ISVM_OFF_LASTADDR: rdSel = {12'h000, lastAddr};
                default:            rdSel = 32'h0000_0000;
            endcase
        end
    end

    // one wait state, read data and error are registered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apbAcc;
            prdata  <= (apbAcc & ~pwrite & mapped) ? rdSel : 32'h0000_0000;
            pslverr <= apbAcc & ~mapped;
        end
    end

    // effective peripheral requests after source selection and two-wire routing
    logic [63:0] effReq;
    always_comb begin
        effReq = periphReq;
        effReq[6] = srcSel[2] ? altReq[0] : periphReq[6];                   // [RULE21]
        effReq[7] = srcSel[3] ? altReq[1] : periphReq[7];                   // [RULE21]
        effReq[8] = srcSel[0] ? altReq[2] : periphReq[8];                   // [RULE21]
        effReq[9] = srcSel[1] ? altReq[3] : periphReq[9];                   // [RULE21]
        if (srcSel[4]) begin
            effReq = (effReq & ~`ISVM_TWO_WIRE_SET) | (twoWireReq & `ISVM_TWO_WIRE_SET); // [RULE22]
        end
    end

    // maskable arbitration: highest level wins, lower number breaks ties
    logic       maskHit;
    logic [5:0] maskNum;
    logic [2:0] maskLvl;
    always_comb begin
        maskHit = 1'b0;
        maskNum = 6'h00;
        maskLvl = `ISVM_PRIO_OFF;
        for (int n = 0; n < 64; n++) begin
            if (request_pending_flag[n] && srcPrio[n] != `ISVM_PRIO_OFF   // [RULE24]
                && srcPrio[n] > flags.processor_priority_level && srcPrio[n] > maskLvl) begin   // [RULE23]
                maskHit = 1'b1;
                maskNum = n[5:0];
                maskLvl = srcPrio[n];
            end
        end
    end

    // source classification while idle; instruction traps first, then address match, non-maskable, special, then maskable
    wire idle     = (state == ST_IDLE);
    wire opUnd    = instrReq.valid & (instrReq.op == OP_UNDEF);              // [RULE13]
    wire opOvf    = instrReq.valid & (instrReq.op == OP_OVF_TRAP) & flags.o; // [RULE14]
    wire opBrk    = instrReq.valid & (instrReq.op == OP_BREAK);              // [RULE15]
    wire opSw     = instrReq.valid & (instrReq.op == OP_SWINT);              // [RULE9]
    wire instrHit = idle & (opUnd | opOvf | opBrk | opSw);                   // [RULE16] [RULE20]
    wire nmiFall  = nmiPrev & ~nmiS2;                                        // [RULE17]
    wire [3:0] mEq;
    for (genvar g = 0; g < 4; g++) begin : g_match
        assign mEq[g] = matchEn[g] & (execAddr == matchAddr[g]);              // [RULE18]
    end
    wire matchHit = idle & ~instrHit & execStrobe & (|mEq);
    wire nmiAcc   = idle & ~instrHit & ~matchHit & nmiPend;
    wire specAcc  = idle & ~instrHit & ~matchHit & ~nmiPend & specialPend;
    wire maskAcc  = idle & ~instrHit & ~matchHit & ~nmiPend & ~specialPend
                  & flags.i & maskHit;                                       // [RULE23]
    wire anyAcc   = instrHit | matchHit | nmiAcc | specAcc | maskAcc;

    // start address and class of the accepted source
    isvm_src_t  accSrc;
    logic [5:0] accNum;
    logic [19:0] accVec;
    always_comb begin
        accSrc = SRC_PERIPH;
        accNum = maskNum;
        accVec = relAddr(vector_table_base, maskNum);                        // [RULE10]
        if (instrHit) begin
            accNum = instrReq.num;
            case (instrReq.op)
                OP_UNDEF:    begin accSrc = SRC_UNDEF; accVec = `ISVM_VEC_UND; end // [RULE3]
                OP_OVF_TRAP: begin accSrc = SRC_OVF;   accVec = `ISVM_VEC_OVF; end // [RULE3]
                OP_BREAK:    begin accSrc = SRC_BREAK; accVec = `ISVM_VEC_BRK_TOP; end
                default: begin
                    accSrc = SRC_SWINT;
                    accVec = relAddr(vector_table_base, instrReq.num);        // [RULE8]
                end
            endcase
        end else if (matchHit) begin
            accSrc = SRC_MATCH;
            accVec = `ISVM_VEC_MATCH;                                        // [RULE2]
        end else if (nmiAcc) begin
            accSrc = SRC_NMI;
            accVec = `ISVM_VEC_NMI;                                          // [RULE2]
        end else if (specAcc) begin
            accSrc = SRC_SHARED;
            accVec = `ISVM_VEC_SHARED;                                       // [RULE4]
        end
    end

    // stack-select is kept only for software numbers 32 to 63
    wire keepU = (accSrc == SRC_SWINT) & (accNum >= `ISVM_SW_USTACK_LO);    // [RULE12]
    wire [2:0] accIpl = (accSrc == SRC_PERIPH) ? maskLvl :
                        (accSrc == SRC_NMI || accSrc == SRC_SHARED) ? `ISVM_IPL_SPECIAL :
                        flags.processor_priority_level;

    // next flag word: entry beats return beats software write
    isvm_flags_t next_flags;
    always_comb begin
        next_flags = flags;
        if (apbWr && paddr == `ISVM_OFF_FLAGS) next_flags = pwdata[5:0];
        if (retStrobe) next_flags = retFlags;                               // [RULE11]
        if (anyAcc) begin
            next_flags.i   = 1'b0;
            next_flags.u   = keepU ? flags.u : 1'b0;                         // [RULE11]
            next_flags.processor_priority_level = accIpl;
        end
    end

    // request flags: a new request wins over acceptance and software clear
    wire [63:0] accOne   = maskAcc ? (64'h1 << maskNum) : 64'h0;
    wire [63:0] swClr    = (apbWr & srcHit & mapped & ~pwdata[`ISVM_SRC_REQ_BIT])
                           ? (64'h1 << srcIdx) : 64'h0;
    wire [63:0] next_req = effReq | (request_pending_flag & ~accOne & ~swClr); // [RULE19]
    wire [2:0]  specEvt  = {lowSupplyReq, oscReq, timeoutReq};
    wire [2:0]  spW1c    = (apbWr && paddr == `ISVM_OFF_SPECIAL) ? pwdata[2:0] : 3'h0;

    // software-visible registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_table_base    <= `ISVM_RST_TBASE;
            flags                <= `ISVM_RST_FLAGS;
            matchEn              <= 4'h0;
            srcSel               <= 5'h00;
            request_pending_flag <= 64'h0;
            specialFlags         <= 3'h0;
            specialPend          <= 1'b0;
            for (int k = 0; k < 4; k++) matchAddr[k] <= 20'h00000;
            for (int k = 0; k < 64; k++) srcPrio[k] <= `ISVM_PRIO_OFF;
        end else begin
            flags                <= next_flags;
            request_pending_flag <= next_req;
            specialFlags         <= specEvt | (specialFlags & ~spW1c);      // [RULE4]
            specialPend          <= (|specEvt) | (specialPend & ~specAcc);
            if (apbWr && paddr == `ISVM_OFF_TBASE) vector_table_base <= pwdata[19:0];
            if (apbWr && paddr == `ISVM_OFF_MATCHEN) matchEn <= pwdata[3:0];
            if (apbWr && paddr == `ISVM_OFF_SRCSEL) srcSel <= pwdata[4:0];
            if (apbWr && mAddrHit && paddr[1:0] == 2'b00) matchAddr[mIdx] <= pwdata[19:0];
            if (apbWr && srcHit && mapped) srcPrio[srcIdx] <= pwdata[2:0];
        end
    end

    // pin synchroniser and falling-edge latch for the non-maskable pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nmiS1   <= 1'b1;
            nmiS2   <= 1'b1;
            nmiPrev <= 1'b1;
            nmiPend <= 1'b0;
        end else begin
            nmiS1   <= nmiPin_n;
            nmiS2   <= nmiS1;
            nmiPrev <= nmiS2;
            nmiPend <= nmiFall | (nmiPend & ~nmiAcc);                       // [RULE17]
        end
    end

    // breakpoint probe decides between fixed and relocatable entry 0
    wire        probeReloc = vfAck & (vfData == `ISVM_BRK_RELOC);           // [RULE5]
    wire [19:0] probeBase  = probeReloc ? vector_table_base : `ISVM_VEC_BRK;
    // odd base adds an align cycle: the table word is split over two accesses
    wire        oddStart   = (accSrc == SRC_SWINT || accSrc == SRC_PERIPH)
                           & vector_table_base[0];                          // [RULE7]

    // vector fetch sequencer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            byteCnt   <= 2'b00;
            fetchBase <= 20'h00000;
            shiftIn   <= 24'h000000;
            vfReq     <= 1'b0;
            vfAddr    <= 20'h00000;
            seqBusy   <= 1'b0;
            entry     <= '0;
            lastNum   <= 6'h00;
            lastAddr  <= 20'h00000;
        end else begin
            entry.valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (anyAcc) begin
                        seqBusy     <= 1'b1;
                        entry.src   <= accSrc;
                        entry.num   <= accNum;
                        entry.saved <= flags;                               // [RULE11]
                        byteCnt     <= 2'b00;
                        fetchBase   <= accVec;
                        vfAddr      <= accVec;
                        vfReq       <= ~oddStart;
                        if (accSrc == SRC_BREAK) state <= ST_PROBE;
                        else if (oddStart) state <= ST_ALIGN;               // [RULE7]
                        else state <= ST_FETCH;
                    end
                end
                ST_PROBE: begin
                    if (vfAck) begin
                        fetchBase <= probeBase;
                        vfAddr    <= probeBase;
                        vfReq     <= ~(probeReloc & vector_table_base[0]);
                        state     <= (probeReloc & vector_table_base[0]) ? ST_ALIGN : ST_FETCH;
                    end
                end
                ST_ALIGN: begin
                    vfReq <= 1'b1;
                    state <= ST_FETCH;
                end
                ST_FETCH: begin
                    if (vfAck) begin
                        shiftIn <= {vfData, shiftIn[23:8]};                 // [RULE25]
                        byteCnt <= byteCnt + 2'b01;
                        vfAddr  <= fetchBase + {18'h0, byteCnt + 2'b01};    // [RULE1]
                        if (byteCnt == 2'b11) begin
                            vfReq       <= 1'b0;
                            entry.addr  <= shiftIn[19:0];                  // [RULE1]
                            state       <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    entry.valid <= 1'b1;
                    seqBusy     <= 1'b0;
                    lastNum     <= entry.num;
                    lastAddr    <= entry.addr;
                    state       <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // checks beside the logic
    property p_und_fixed;
        @(posedge core_clk) disable iff (!rst_n)
        (instrHit && instrReq.op == OP_UNDEF) |=> (vfReq && vfAddr == `ISVM_VEC_UND);
    endproperty
    a_und_fixed: assert property (p_und_fixed) else $error("undefined trap vector wrong"); // [RULE3]

    property p_ovf_gate;
        @(posedge core_clk) disable iff (!rst_n)
        (idle && instrReq.valid && instrReq.op == OP_OVF_TRAP && !flags.o
         && !matchHit && !nmiPend && !specialPend && !(flags.i && maskHit)) |=> !seqBusy;
    endproperty
    a_ovf_gate: assert property (p_ovf_gate) else $error("overflow trap without flag"); // [RULE14]

    property p_sw_addr;
        @(posedge core_clk) disable iff (!rst_n)
        (instrHit && instrReq.op == OP_SWINT && !vector_table_base[0])
        |=> (vfReq && vfAddr == $past(vector_table_base) + {12'h000, $past(instrReq.num), 2'b00});
    endproperty
    a_sw_addr: assert property (p_sw_addr) else $error("software vector address wrong"); // [RULE8]

    property p_odd_slow;
        @(posedge core_clk) disable iff (!rst_n)
        (anyAcc && oddStart) |=> !vfReq ##1 vfReq;
    endproperty
    a_odd_slow: assert property (p_odd_slow) else $error("odd base not delayed"); // [RULE7]

    property p_nmi_edge;
        @(posedge core_clk) disable iff (!rst_n)
        $fell(nmiS2) |=> nmiPend;
    endproperty
    a_nmi_edge: assert property (p_nmi_edge) else $error("pin fall not latched"); // [RULE17]

    property p_shared_vec;
        @(posedge core_clk) disable iff (!rst_n)
        specAcc |=> (vfAddr == `ISVM_VEC_SHARED && entry.src == SRC_SHARED);
    endproperty
    a_shared_vec: assert property (p_shared_vec) else $error("shared vector wrong"); // [RULE4]

    property p_mask_cond;
        @(posedge core_clk) disable iff (!rst_n)
        maskAcc |-> (flags.i && request_pending_flag[maskNum] && srcPrio[maskNum] > flags.processor_priority_level);
    endproperty
    a_mask_cond: assert property (p_mask_cond) else $error("maskable accepted wrongly"); // [RULE23]

    property p_ustack;
        @(posedge core_clk) disable iff (!rst_n)
        (instrHit && instrReq.op == OP_SWINT && instrReq.num >= `ISVM_SW_USTACK_LO)
        |=> flags.u == $past(flags.u);
    endproperty
    a_ustack: assert property (p_ustack) else $error("stack select changed"); // [RULE12]

    property p_entry_done;
        @(posedge core_clk) disable iff (!rst_n)
        (state == ST_FETCH && vfAck && byteCnt == 2'b11) |=> !vfReq ##1 entry.valid;
    endproperty
    a_entry_done: assert property (p_entry_done) else $error("entry not raised"); // [RULE1]

endmodule // isvm_top

// ---- test/isvm_vec_mem.sv ----
// vector byte memory model answering the design's fetch requests
`timescale 1ns/100ps
module isvm_vec_mem (
    // fetch port
    input  wire logic        core_clk,
    input  wire logic        vfReq,
    input  wire logic [19:0] vfAddr,
    output logic      [7:0]  vfData,
    output logic             vfAck,
    // behaviour controls
    input  wire logic        slow,
    input  wire logic        brkReloc
);
    logic       tick = 1'b0;
    // the breakpoint top byte reads all ones only when relocation is wanted
    wire  [7:0] memByte = (vfAddr == 20'hfffe7 && brkReloc) ? 8'hff : vfAddr[7:0];
    // slow mode answers every other cycle; unanswered data is inverted, never stale
    always_ff @(posedge core_clk) tick <= ~tick;
    assign vfAck  = vfReq && (!slow || tick);
    assign vfData = vfAck ? memByte : ~memByte;
endmodule // isvm_vec_mem

// ---- test/testbench.sv ----
// self-checking bench for the interrupt source vector map
`timescale 1ns/100ps
module testbench import isvm_pkg::*;;
    logic        core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, rerr, seqBusy, vfReq, vfAck, slow = 1'b0, breakpoint_instr = 1'b0;
    logic [2:0]  pulse = 3'h0;
    logic        nmiPin_n = 1'b1;
    logic [19:0] execAddr = 20'h0abcd, vfAddr;
    logic [7:0]  vfData;
    logic [63:0] periphReq = 64'h0, twoW = 64'h0;
    isvm_instr_t instrReq = '0;
    isvm_entry_t entry;
    isvm_flags_t flags;
    int          bad_count = 0, cmp_count = 0, evenCyc, oddCyc, c;
    always #25 core_clk = ~core_clk;
    // pulse[0] timeout, pulse[1] execute strobe, pulse[2] return strobe
    isvm_top DUT (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .instrReq, .execStrobe(pulse[1]), .execAddr, .retStrobe(pulse[2]),
        .retFlags(6'h04), .seqBusy, .entry, .flags, .vfReq, .vfAddr, .vfData, .vfAck,
        .nmiPin_n, .timeoutReq(pulse[0]), .oscReq(1'b0), .lowSupplyReq(1'b0), .periphReq,
        .altReq(4'h0), .twoWireReq(twoW));
    isvm_vec_mem MEM (.core_clk, .vfReq, .vfAddr, .vfData, .vfAck, .slow, .brkReloc(breakpoint_instr));
    function automatic logic [19:0] vec(input logic [19:0] v);
        logic [19:0] v2;
        v2 = v + 20'h2;
        return {v2[3:0], 8'(v + 20'h1), v[7:0]};
    endfunction
    task automatic give_verdict(input logic hang);
        bad_count += hang;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) bad_count++;
        if (got !== exp) $display("mismatch at %0t got %h expected %h", $time, got, exp);
    endtask
    // apb master: request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge core_clk);
        {rdat, rerr} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (k == 20) give_verdict(1'b1);
    endtask
    task automatic pls(input logic [2:0] m);
        @(posedge core_clk);
        pulse <= m;
        @(posedge core_clk);
        pulse <= 3'h0;
    endtask
    task automatic instr(input isvm_op_t op, input logic [5:0] n);
        @(posedge core_clk);
        instrReq <= '{1'b1, op, n};
        @(posedge core_clk);
        instrReq <= '0;
    endtask
    // entry wait is bounded; the cycle count feeds the base parity check
    task automatic await(input logic [19:0] ea, input isvm_src_t es, output int n);
        for (n = 0; n < 100 && entry.valid !== 1'b1; n++) @(negedge core_clk);
        if (n == 100) give_verdict(1'b1);
        cmp({entry.src, entry.addr, seqBusy}, {es, ea, 1'b0});
    endtask
    task automatic quiet();
        logic hit;
        hit = 1'b0;
        repeat (20) @(negedge core_clk) hit |= (entry.valid === 1'b1);
        cmp(32'(hit), 32'h0);
    endtask
    task automatic s_fixed();
        instr(OP_UNDEF, 6'h00);
        await(vec(20'hfffdc), SRC_UNDEF, c);
        slow <= 1'b1;
        instr(OP_OVF_TRAP, 6'h00);
        quiet();
        apb(1'b1, 12'h004, 32'h02);
        instr(OP_OVF_TRAP, 6'h00);
        await(vec(20'hfffe0), SRC_OVF, c);
        slow <= 1'b0;
        instr(OP_BREAK, 6'h00);
        await(vec(20'hfffe4), SRC_BREAK, c);
    endtask
    task automatic s_soft();
        apb(1'b1, 12'h000, 32'h12340);
        apb(1'b1, 12'h004, 32'h04);
        instr(OP_SWINT, 6'h02);
        await(vec(20'h12348), SRC_SWINT, evenCyc);
        cmp({flags.u, entry.saved.u}, 2'b01);
        apb(1'b1, 12'h004, 32'h04);
        instr(OP_SWINT, 6'h28);
        await(vec(20'h123e0), SRC_SWINT, c);
        cmp(flags.u, 1'b1);
        pls(3'h4);
        @(negedge core_clk);
        cmp(flags, 6'h04);
        apb(1'b1, 12'h000, 32'h12341);
        instr(OP_SWINT, 6'h02);
        await(vec(20'h12349), SRC_SWINT, oddCyc);
        cmp(oddCyc > evenCyc, 1'b1);
        breakpoint_instr <= 1'b1;
        instr(OP_BREAK, 6'h00);
        await(vec(20'h12341), SRC_BREAK, c);
    endtask
    task automatic s_hw();
        apb(1'b1, 12'h114, 32'h3);
        apb(1'b1, 12'h004, 32'h00);
        periphReq[5] <= 1'b1;
        @(posedge core_clk);
        periphReq[5] <= 1'b0;
        quiet();
        apb(1'b1, 12'h004, 32'h01);
        await(vec(20'h12355), SRC_PERIPH, c);
        cmp(flags.processor_priority_level, 3'h3);
        pls(3'h1);
        await(vec(20'hffff0), SRC_SHARED, c);
        apb(1'b0, 12'h020, 32'h0);
        cmp(rdat, 32'h1);
        cmp(flags.processor_priority_level, 3'h7);
        nmiPin_n <= 1'b0;
        await(vec(20'hffff8), SRC_NMI, c);
        apb(1'b1, 12'h010, 32'h0abcd);
        apb(1'b1, 12'h008, 32'h1);
        pls(3'h2);
        await(vec(20'hfffe8), SRC_MATCH, c);
        apb(1'b0, 12'h028, 32'h0);
        cmp(rdat, 32'(vec(20'hfffe8)));
        apb(1'b1, 12'h00c, 32'h10);
        apb(1'b1, 12'h128, 32'h1);
        apb(1'b1, 12'h004, 32'h01);
        twoW[10] <= 1'b1;
        @(posedge core_clk);
        twoW[10] <= 1'b0;
        await(vec(20'h12369), SRC_PERIPH, c);
        apb(1'b0, 12'h0fc, 32'h0);
        cmp(rdat, 32'h0);
        cmp(rerr, 1'b1);
    endtask
    // reset for four cycles, then the scenarios in turn
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        s_fixed();
        s_soft();
        s_hw();
        give_verdict(1'b0);
    end
endmodule // testbench
